// [rtl/pio_consts.svh]
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// Register offsets on the plain register port.
`define PIO_REG_DIN_BASE    8'h00
`define PIO_REG_DOUT_BASE   8'h04
`define PIO_REG_DIR_BASE    8'h08
`define PIO_REG_CTRL_BASE   8'h0C
`define PIO_REG_MC_BASE     8'h10
`define PIO_REG_IMC_BASE    8'h14
`define PIO_REG_MEMMAP      8'h18

// Layout and reset values.
`define PIO_NUM_PORTS       4
`define PIO_NUM_CTRL        2
`define PIO_NUM_IMC         3
`define PIO_RST_BYTE        8'h00
`define PIO_MASK_FULL       8'hFF
`define PIO_MASK_D          8'h07
`define PIO_PERIPH_BIT      7
`define PIO_RDATA_IDLE      8'h00

`endif

// [rtl/pio_imc.sv]
`timescale 1ns/10ps
`include "pio_consts.svh"

module pio_imc
(
  input  wire logic                  clk,      // Bus clock.
  input  wire logic                  reset,    // Synchronous, high.
  input  wire logic                  ce,       // Clock enable.
  input  wire logic [7:0]            pin,      // Pin levels.
  input  wire pio_pkg::pio_imc_mode_t mode,    // Fixed cell mode.
  input  wire logic                  use_pt,   // Strobe from product term.
  input  wire logic [1:0]            pt,       // Terms: [0] bits 3-0.
  input  wire logic                  ale,      // Address latch strobe.
  output logic      [7:0]            imc_out   // Cell outputs.
);

  logic [1:0] stb;
  logic [1:0] stb_prev;
  logic [7:0] next_imc;

  // ***********************************************************
  // Strobe selection, one term per nibble.
  // ***********************************************************
  assign stb = use_pt ? pt : {2{ale}};

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      always_comb
      begin
        next_imc[b] = imc_out[b];
        case (mode)
          pio_pkg::PIO_IMC_LATCH:
            if (stb[b / 4])
              next_imc[b] = pin[b];
          pio_pkg::PIO_IMC_REGISTER:
            if (stb[b / 4] && !stb_prev[b / 4])
              next_imc[b] = pin[b];
          default:
            next_imc[b] = pin[b];
        endcase
      end
    end
  endgenerate

  // The strobe is sampled, so a register captures on its rising edge.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      imc_out  <= `PIO_RST_BYTE;
      stb_prev <= 2'h0;
    end
    else if (ce)
    begin
      imc_out  <= next_imc;
      stb_prev <= stb;
    end
  end

  a_imc_hold: assert property (@(posedge clk) disable iff (reset)
    ce && mode == pio_pkg::PIO_IMC_REGISTER && !use_pt && !ale
    |=> imc_out == $past(imc_out))
    else $error("register cell changed without strobe edge");

endmodule

// [rtl/pio_pkg.sv]
package pio_pkg;

  typedef enum logic [1:0]
  {
    PIO_IMC_DIRECT,
    PIO_IMC_LATCH,
    PIO_IMC_REGISTER
  } pio_imc_mode_t;

  typedef logic [7:0] pio_byte_t;

endpackage

// [rtl/pio_ports.sv]
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "pio_consts.svh"

// Overview of operation
// - Four ports, three of eight bits, one three.
// - Output mux: data, address, macrocell, chip select.
// - Readback drives one selected source at once.
// - Readback covers data, cells, direction, control, pins.
// - Driver enable is product term OR direction.
// - Undefined term leaves direction bit in control.
// - Input cells latch, register or pass inputs.
// - Fixed configuration modes; others set at run time.
// - Control bit zero selects processor I/O mode.
// - Processor mode drives data register, reads pins.
// - Ports three and four lack control registers.
// - Logic outputs tri-state by term or direction.
// - Address out needs enable or direction plus control.
// - Memory map bit seven makes first port buffer.
// - Buffer floats while both peripheral selects low.
// - Control one selects address out; zero default.
// - Direction one output, zero input; default input.
// - Configuration registers power up as zero.

module pio_ports
(
  input  wire logic                   CLK,            // 40 MHz bus clock.
  input  wire logic                   RESET,          // Synchronous, high.
  input  wire logic                   CE,             // Clock enable.
  input  wire logic [7:0]             ADDR,           // Register address.
  input  wire logic [7:0]             WDATA,          // Write data.
  input  wire logic                   WR,             // Write strobe.
  input  wire logic                   RD,             // Read strobe.
  output logic      [7:0]             RDATA,          // Read data.
  input  wire logic [7:0]             PA_IN,          // Port A pin level.
  output logic      [7:0]             PA_OUT,         // Port A drive value.
  output logic      [7:0]             PA_OE,          // Port A enable.
  input  wire logic [7:0]             PB_IN,          // Port B pin level.
  output logic      [7:0]             PB_OUT,         // Port B drive value.
  output logic      [7:0]             PB_OE,          // Port B enable.
  input  wire logic [7:0]             PC_IN,          // Port C pin level.
  output logic      [7:0]             PC_OUT,         // Port C drive value.
  output logic      [7:0]             PC_OE,          // Port C enable.
  input  wire logic [2:0]             PD_IN,          // Port D pin level.
  output logic      [2:0]             PD_OUT,         // Port D drive value.
  output logic      [2:0]             PD_OE,          // Port D enable.
  input  wire logic [7:0]             CFG_LOGIC_OUT_A, // A pins as cell out.
  input  wire logic [7:0]             CFG_LOGIC_OUT_B, // B pins as cell out.
  input  wire logic [7:0]             CFG_LOGIC_OUT_C, // C pins as cell out.
  input  wire logic [2:0]             CFG_ECS_D,      // D pins as selects.
  input  wire logic [7:0]             MC_OUT_A,       // Macrocells to A.
  input  wire logic [7:0]             MC_OUT_B,       // Macrocells to B.
  input  wire logic [7:0]             MC_OUT_C,       // Macrocells to C.
  input  wire logic [2:0]             EXTRA_CHIP_SELECTS, // Selects to D.
  input  wire logic [7:0]             CFG_OE_PT_A,    // A enable term used.
  input  wire logic [7:0]             CFG_OE_PT_B,    // B enable term used.
  input  wire logic [7:0]             CFG_OE_PT_C,    // C enable term used.
  input  wire logic [2:0]             CFG_OE_PT_D,    // D enable term used.
  input  wire logic [7:0]             OE_PT_A,        // A enable terms.
  input  wire logic [7:0]             OE_PT_B,        // B enable terms.
  input  wire logic [7:0]             OE_PT_C,        // C enable terms.
  input  wire logic [2:0]             OE_PT_D,        // D enable terms.
  input  wire logic [7:0]             ADDR_LATCH,     // Latched a7-a0.
  input  wire logic                   ALE,            // Address strobe.
  input  wire pio_pkg::pio_imc_mode_t CFG_IMC_MODE_A, // A input cell mode.
  input  wire pio_pkg::pio_imc_mode_t CFG_IMC_MODE_B, // B input cell mode.
  input  wire pio_pkg::pio_imc_mode_t CFG_IMC_MODE_C, // C input cell mode.
  input  wire logic [2:0]             CFG_IMC_USE_PT, // Term strobe A,B,C.
  input  wire logic [5:0]             IMC_PT,         // Nibble terms A,B,C.
  output logic      [7:0]             IMC_BUS_A,      // A cells to logic.
  output logic      [7:0]             IMC_BUS_B,      // B cells to logic.
  output logic      [7:0]             IMC_BUS_C,      // C cells to logic.
  input  wire logic                   PERIPH_SELECT_A, // Peripheral select.
  input  wire logic                   PERIPH_SELECT_B, // Peripheral select.
  input  wire logic                   PERIPH_WRITE,   // Processor writes out.
  input  wire logic [7:0]             BUS_DATA,       // Processor data out.
  output logic      [7:0]             PERIPH_DATA     // Port A to processor.
);

  // ***********************************************************
  // Per-port views, all but the cell modes held eight bits wide.
  // ***********************************************************
  logic [7:0] pin_in   [`PIO_NUM_PORTS];
  logic [7:0] cfg_lo   [`PIO_NUM_PORTS];
  logic [7:0] cfg_ecs  [`PIO_NUM_PORTS];
  logic [7:0] mc_out   [`PIO_NUM_PORTS];
  logic [7:0] cfg_pt   [`PIO_NUM_PORTS];
  logic [7:0] oe_pt    [`PIO_NUM_PORTS];
  logic [7:0] port_msk [`PIO_NUM_PORTS];
  logic [7:0] imc_bus  [`PIO_NUM_IMC];
  pio_pkg::pio_imc_mode_t imc_mode [`PIO_NUM_IMC];

  assign pin_in  = '{PA_IN, PB_IN, PC_IN, {5'h00, PD_IN}};
  assign cfg_lo  = '{CFG_LOGIC_OUT_A, CFG_LOGIC_OUT_B, CFG_LOGIC_OUT_C,
                     `PIO_RST_BYTE};
  assign cfg_ecs = '{`PIO_RST_BYTE, `PIO_RST_BYTE, `PIO_RST_BYTE,
                     {5'h00, CFG_ECS_D}};
  assign mc_out  = '{MC_OUT_A, MC_OUT_B, MC_OUT_C,
                     {5'h00, EXTRA_CHIP_SELECTS}};
  assign cfg_pt  = '{CFG_OE_PT_A, CFG_OE_PT_B, CFG_OE_PT_C,
                     {5'h00, CFG_OE_PT_D}};
  assign oe_pt   = '{OE_PT_A, OE_PT_B, OE_PT_C, {5'h00, OE_PT_D}};
  assign port_msk = '{`PIO_MASK_FULL, `PIO_MASK_FULL, `PIO_MASK_FULL,
                      `PIO_MASK_D};
  assign imc_mode = '{CFG_IMC_MODE_A, CFG_IMC_MODE_B, CFG_IMC_MODE_C};

  // ***********************************************************
  // Configuration registers and register port.
  // ***********************************************************
  logic [7:0] dout        [`PIO_NUM_PORTS];
  logic [7:0] dir         [`PIO_NUM_PORTS];
  logic [7:0] ctrl        [`PIO_NUM_CTRL];
  logic [7:0] memmap;
  logic [7:0] next_dout   [`PIO_NUM_PORTS];
  logic [7:0] next_dir    [`PIO_NUM_PORTS];
  logic [7:0] next_ctrl   [`PIO_NUM_CTRL];
  logic [7:0] next_memmap;
  logic [7:0] next_rdata;

  always_comb
  begin
    next_dout   = dout;
    next_dir    = dir;
    next_ctrl   = ctrl;
    next_memmap = memmap;
    if (WR)
    begin
      for (int i = 0; i < `PIO_NUM_PORTS; i++)
      begin
        if (ADDR == `PIO_REG_DOUT_BASE + 8'(i))
          next_dout[i] = WDATA & port_msk[i];
        else if (ADDR == `PIO_REG_DIR_BASE + 8'(i))
          next_dir[i] = WDATA & port_msk[i];
        else if (i < `PIO_NUM_CTRL && ADDR == `PIO_REG_CTRL_BASE + 8'(i))
          next_ctrl[i] = WDATA;
      end
      if (ADDR == `PIO_REG_MEMMAP)
        next_memmap = WDATA;
    end
  end

  // One source at a time is steered onto the read data; unmapped reads
  // and idle cycles return zero so the bus sees a defined value.
  always_comb
  begin
    next_rdata = `PIO_RDATA_IDLE;
    if (RD)
    begin
      for (int i = 0; i < `PIO_NUM_PORTS; i++)
      begin
        if (ADDR == `PIO_REG_DIN_BASE + 8'(i))
          next_rdata = pin_in[i];
        else if (ADDR == `PIO_REG_DOUT_BASE + 8'(i))
          next_rdata = dout[i];
        else if (ADDR == `PIO_REG_DIR_BASE + 8'(i))
          next_rdata = dir[i];
        else if (i < `PIO_NUM_CTRL && ADDR == `PIO_REG_CTRL_BASE + 8'(i))
          next_rdata = ctrl[i];
        else if (i < `PIO_NUM_IMC && ADDR == `PIO_REG_MC_BASE + 8'(i))
          next_rdata = mc_out[i];
        else if (i < `PIO_NUM_IMC && ADDR == `PIO_REG_IMC_BASE + 8'(i))
          next_rdata = imc_bus[i];
      end
      if (ADDR == `PIO_REG_MEMMAP)
        next_rdata = memmap;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      dout   <= '{default: `PIO_RST_BYTE};
      dir    <= '{default: `PIO_RST_BYTE};
      ctrl   <= '{default: `PIO_RST_BYTE};
      memmap <= `PIO_RST_BYTE;
      RDATA  <= `PIO_RDATA_IDLE;
    end
    else if (CE)
    begin
      dout   <= next_dout;
      dir    <= next_dir;
      ctrl   <= next_ctrl;
      memmap <= next_memmap;
      RDATA  <= next_rdata;
    end
  end

  // ***********************************************************
  // Output multiplexer and driver enables.
  // ***********************************************************
  // Pins are computed from the next register values so a write shows on
  // the pins at the same edge that stores it, one cycle after the strobe.
  logic       periph_on;
  logic       periph_drive;
  logic [7:0] pin_out      [`PIO_NUM_PORTS];
  logic [7:0] pin_oe       [`PIO_NUM_PORTS];
  logic [7:0] next_pin_out [`PIO_NUM_PORTS];
  logic [7:0] next_pin_oe  [`PIO_NUM_PORTS];
  logic [7:0] next_periph;

  assign periph_on    = next_memmap[`PIO_PERIPH_BIT];
  assign periph_drive = (PERIPH_SELECT_A | PERIPH_SELECT_B) & PERIPH_WRITE;

  genvar p;
  generate
    for (p = 0; p < `PIO_NUM_PORTS; p++)
    begin : g_port
      logic [7:0] ctl;
      logic [7:0] cpu_val;
      if (p < `PIO_NUM_CTRL)
      begin : g_ctl
        assign ctl = next_ctrl[p];
      end
      else
      begin : g_noctl
        assign ctl = `PIO_RST_BYTE;
      end

      // Control zero gives processor data, one gives the latched address.
      assign cpu_val = (ctl & ADDR_LATCH) | (~ctl & next_dout[p]);

      always_comb
      begin
        next_pin_out[p] = ((cfg_lo[p] | cfg_ecs[p]) & mc_out[p])
                        | (~(cfg_lo[p] | cfg_ecs[p]) & cpu_val);
        // Undefined terms are masked out, leaving the direction bit alone.
        next_pin_oe[p] = (cfg_pt[p] & oe_pt[p]) | next_dir[p];
        if (p == 0 && periph_on)
        begin
          next_pin_out[p] = BUS_DATA;
          next_pin_oe[p]  = {8{periph_drive}};
        end
        next_pin_out[p] = next_pin_out[p] & port_msk[p];
        next_pin_oe[p]  = next_pin_oe[p] & port_msk[p];
      end
    end
  endgenerate

  assign next_periph = periph_on ? PA_IN : `PIO_RST_BYTE;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pin_out     <= '{default: `PIO_RST_BYTE};
      pin_oe      <= '{default: `PIO_RST_BYTE};
      PERIPH_DATA <= `PIO_RST_BYTE;
    end
    else if (CE)
    begin
      pin_out     <= next_pin_out;
      pin_oe      <= next_pin_oe;
      PERIPH_DATA <= next_periph;
    end
  end

  assign PA_OUT = pin_out[0];
  assign PA_OE  = pin_oe[0];
  assign PB_OUT = pin_out[1];
  assign PB_OE  = pin_oe[1];
  assign PC_OUT = pin_out[2];
  assign PC_OE  = pin_oe[2];
  assign PD_OUT = pin_out[3][2:0];
  assign PD_OE  = pin_oe[3][2:0];

  // ***********************************************************
  // Input macrocells on the first three ports.
  // ***********************************************************
  generate
    for (p = 0; p < `PIO_NUM_IMC; p++)
    begin : g_imc
      pio_imc u_imc
      (
        .clk     (CLK),
        .reset   (RESET),
        .ce      (CE),
        .pin     (pin_in[p]),
        .mode    (imc_mode[p]),
        .use_pt  (CFG_IMC_USE_PT[p]),
        .pt      (IMC_PT[2 * p +: 2]),
        .ale     (ALE),
        .imc_out (imc_bus[p])
      );
    end
  endgenerate

  assign IMC_BUS_A = imc_bus[0];
  assign IMC_BUS_B = imc_bus[1];
  assign IMC_BUS_C = imc_bus[2];

  // ***********************************************************
  // Checks.
  // ***********************************************************
  a_reset_clears: assert property (@(posedge CLK)
    RESET |=> dir[0] == `PIO_RST_BYTE && ctrl[1] == `PIO_RST_BYTE
              && memmap == `PIO_RST_BYTE && PB_OE == `PIO_RST_BYTE)
    else $error("registers not zero after reset");

  a_dir_write: assert property (@(posedge CLK) disable iff (RESET)
    CE && WR && ADDR == `PIO_REG_DIR_BASE + 8'h01 && !CFG_OE_PT_B[0]
    |=> PB_OE[0] == $past(WDATA[0])
    ##1 (!CE || PB_OE[0] == dir[1][0]))
    else $error("direction write did not reach the pin enable");

  a_oe_or: assert property (@(posedge CLK) disable iff (RESET)
    CE && !WR |=> PC_OE == ($past(dir[2]) | ($past(CFG_OE_PT_C)
                                         & $past(OE_PT_C))))
    else $error("enable is not term or direction");

  a_addr_out: assert property (@(posedge CLK) disable iff (RESET)
    CE && !WR && ctrl[0][7] && !CFG_LOGIC_OUT_A[7] && !memmap[`PIO_PERIPH_BIT]
    |=> PA_OUT[7] == $past(ADDR_LATCH[7]))
    else $error("address out mode did not drive latched address");

  a_cpu_io: assert property (@(posedge CLK) disable iff (RESET)
    CE && !WR && !CFG_LOGIC_OUT_C[0] |=> PC_OUT[0] == $past(dout[2][0]))
    else $error("processor mode pin does not follow data register");

  a_periph_off: assert property (@(posedge CLK) disable iff (RESET)
    CE && !WR && memmap[`PIO_PERIPH_BIT] && !PERIPH_SELECT_A
    && !PERIPH_SELECT_B |=> PA_OE == `PIO_RST_BYTE)
    else $error("peripheral buffer driven without select");

  a_read_dir: assert property (@(posedge CLK) disable iff (RESET)
    CE && RD && ADDR == `PIO_REG_DIR_BASE + 8'h01
    |=> RDATA == $past(dir[1]))
    else $error("direction readback wrong");

  a_read_idle: assert property (@(posedge CLK) disable iff (RESET)
    CE && !RD |=> RDATA == `PIO_RDATA_IDLE)
    else $error("read data not idle outside a read");

  a_pd_width: assert property (@(posedge CLK) disable iff (RESET)
    (dir[3] & ~`PIO_MASK_D) == `PIO_RST_BYTE
    && (dout[3] & ~`PIO_MASK_D) == `PIO_RST_BYTE)
    else $error("port D holds bits above its width");

endmodule

// [verif/pio_pin_model.sv]
`timescale 1ns/10ps

// ********************************************************************
// Devices on the pins of one port
// ********************************************************************
// A pin that nobody drives shows the inverse of its last level, so a
// floating wire never passes for a stable value.
module pio_pin_model
#(
  parameter int W = 8
)
(
  input  wire logic         clk,     // Bus clock.
  input  wire logic [W-1:0] out,     // Port drive value.
  input  wire logic [W-1:0] oe,      // Port drive enable.
  input  wire logic [W-1:0] ext_val, // Device drive value.
  input  wire logic [W-1:0] ext_en,  // Device drive enable.
  output logic      [W-1:0] pin      // Level on the wire.
);
  logic [W-1:0] last = '0;

  always_ff @(posedge clk)
    last <= pin;

  // Two drivers at once give an unknown level.
  always_comb
    for (int i = 0; i < W; i++)
      if (oe[i] && ext_en[i])
        pin[i] = 1'bx;
      else if (oe[i])
        pin[i] = out[i];
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else
        pin[i] = ~last[i];
endmodule

// [verif/pio_ports_tb_top.sv]
`timescale 1ns/10ps
`include "pio_consts.svh"
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))

module pio_ports_tb_top;
  typedef struct packed {logic [7:0] a, w, r;} pio_row_t;

  // ******************************************************************
  // Signals and instances
  // ******************************************************************
  logic                   CLK, RESET, CE, WR, RD, ALE, PERIPH_WRITE;
  logic                   PERIPH_SELECT_A, PERIPH_SELECT_B;
  logic [7:0]             ADDR, WDATA, RDATA, PA_IN, PA_OUT, PA_OE, PB_IN;
  logic [7:0]             PB_OUT, PB_OE, PC_IN, PC_OUT, PC_OE, ADDR_LATCH;
  logic [7:0]             CFG_LOGIC_OUT_A, CFG_LOGIC_OUT_B, CFG_LOGIC_OUT_C;
  logic [7:0]             MC_OUT_A, MC_OUT_B, MC_OUT_C, BUS_DATA, PERIPH_DATA;
  logic [7:0]             CFG_OE_PT_A, CFG_OE_PT_B, CFG_OE_PT_C;
  logic [7:0]             OE_PT_A, OE_PT_B, OE_PT_C;
  logic [7:0]             IMC_BUS_A, IMC_BUS_B, IMC_BUS_C;
  logic [2:0]             PD_IN, PD_OUT, PD_OE, CFG_ECS_D, EXTRA_CHIP_SELECTS;
  logic [2:0]             CFG_OE_PT_D, OE_PT_D, CFG_IMC_USE_PT, ext_d, en_d;
  logic [5:0]             IMC_PT;
  logic [7:0]             ext_a, ext_b, ext_c, en_a, en_b, en_c;
  logic                   prog_store;
  pio_pkg::pio_imc_mode_t CFG_IMC_MODE_A, CFG_IMC_MODE_B, CFG_IMC_MODE_C;
  int                     error_cnt, tests_run, cycles;

  pio_row_t rows [12] = '{'{8'h04, 8'hA5, 8'hA5}, '{8'h05, 8'h5A, 8'h5A},
    '{8'h06, 8'hC3, 8'hC3}, '{8'h07, 8'hFF, 8'h07}, '{8'h08, 8'h0F, 8'h0F},
    '{8'h09, 8'hF0, 8'hF0}, '{8'h0A, 8'h3C, 8'h3C}, '{8'h0B, 8'hFF, 8'h07},
    '{8'h0C, 8'h00, 8'h00}, '{8'h0D, 8'h00, 8'h00}, '{8'h1F, 8'hFF, 8'h00},
    '{8'h18, 8'h00, 8'h00}};

  pio_ports dut
  (
    .CLK(CLK), .RESET(RESET), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
    .PA_OE(PA_OE), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE(PB_OE),
    .PC_IN(PC_IN), .PC_OUT(PC_OUT), .PC_OE(PC_OE), .PD_IN(PD_IN),
    .PD_OUT(PD_OUT), .PD_OE(PD_OE), .CFG_LOGIC_OUT_A(CFG_LOGIC_OUT_A),
    .CFG_LOGIC_OUT_B(CFG_LOGIC_OUT_B), .CFG_LOGIC_OUT_C(CFG_LOGIC_OUT_C),
    .CFG_ECS_D(CFG_ECS_D), .MC_OUT_A(MC_OUT_A), .MC_OUT_B(MC_OUT_B),
    .MC_OUT_C(MC_OUT_C), .EXTRA_CHIP_SELECTS(EXTRA_CHIP_SELECTS),
    .CFG_OE_PT_A(CFG_OE_PT_A), .CFG_OE_PT_B(CFG_OE_PT_B),
    .CFG_OE_PT_C(CFG_OE_PT_C), .CFG_OE_PT_D(CFG_OE_PT_D),
    .OE_PT_A(OE_PT_A), .OE_PT_B(OE_PT_B), .OE_PT_C(OE_PT_C),
    .OE_PT_D(OE_PT_D), .ADDR_LATCH(ADDR_LATCH), .ALE(ALE),
    .CFG_IMC_MODE_A(CFG_IMC_MODE_A), .CFG_IMC_MODE_B(CFG_IMC_MODE_B),
    .CFG_IMC_MODE_C(CFG_IMC_MODE_C), .CFG_IMC_USE_PT(CFG_IMC_USE_PT),
    .IMC_PT(IMC_PT), .IMC_BUS_A(IMC_BUS_A), .IMC_BUS_B(IMC_BUS_B),
    .IMC_BUS_C(IMC_BUS_C), .PERIPH_SELECT_A(PERIPH_SELECT_A),
    .PERIPH_SELECT_B(PERIPH_SELECT_B), .PERIPH_WRITE(PERIPH_WRITE),
    .BUS_DATA(BUS_DATA), .PERIPH_DATA(PERIPH_DATA)
  );

  pio_pin_model #(.W(8)) pins_a (.clk(CLK), .out(PA_OUT), .oe(PA_OE),
    .ext_val(ext_a), .ext_en(en_a), .pin(PA_IN));
  pio_pin_model #(.W(8)) pins_b (.clk(CLK), .out(PB_OUT), .oe(PB_OE),
    .ext_val(ext_b), .ext_en(en_b), .pin(PB_IN));
  pio_pin_model #(.W(8)) pins_c (.clk(CLK), .out(PC_OUT), .oe(PC_OE),
    .ext_val(ext_c), .ext_en(en_c), .pin(PC_IN));
  pio_pin_model #(.W(3)) pins_d (.clk(CLK), .out(PD_OUT), .oe(PD_OE),
    .ext_val(ext_d), .ext_en(en_d), .pin(PD_IN));

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // ******************************************************************
  // Clock, watchdog and sequence
  // ******************************************************************
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // The whole sequence needs some 125 cycles.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    logic [7:0] d;
    RESET = 1'b1;
    CE = 1'b1;
    {WR, RD, ALE, PERIPH_SELECT_A, PERIPH_SELECT_B, PERIPH_WRITE} = '0;
    {ADDR, WDATA, CFG_LOGIC_OUT_A, CFG_LOGIC_OUT_B, CFG_LOGIC_OUT_C} = '0;
    {MC_OUT_A, MC_OUT_B, MC_OUT_C, CFG_ECS_D, EXTRA_CHIP_SELECTS} = '0;
    {CFG_OE_PT_A, CFG_OE_PT_B, CFG_OE_PT_C, CFG_OE_PT_D} = '0;
    {OE_PT_A, OE_PT_B, OE_PT_C, OE_PT_D, ADDR_LATCH, IMC_PT, BUS_DATA} = '0;
    CFG_IMC_MODE_A = pio_pkg::PIO_IMC_DIRECT;
    CFG_IMC_MODE_B = pio_pkg::PIO_IMC_REGISTER;
    CFG_IMC_MODE_C = pio_pkg::PIO_IMC_LATCH;
    CFG_IMC_USE_PT = 3'b100;
    {ext_a, en_a, ext_b, ext_c} = {8'h90, 8'hF0, 8'h3C, 8'hA5};
    {en_b, en_c, ext_d, en_d} = '0;
    {error_cnt, tests_run, cycles} = '0;
    prog_store = 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK("readback", rows[i].r, d);
    end
    `CHK("PA_OUT", 8'hA5, PA_OUT);
    `CHK("PA_OE", 8'h0F, PA_OE);
    `CHK("PB_OE", 8'hF0, PB_OE);
    `CHK("PC_OUT", 8'hC3, PC_OUT);
    `CHK("PD_OE", 8'h07, PD_OE);
    rd(8'h00, d);
    `CHK("pins A", 8'h95, d);
    // Write and read of one register back to back.
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= 8'h08;
    WDATA <= 8'hFF;
    en_a <= 8'h00;
    #1;
    `CHK("PA_OE before", 8'h0F, PA_OE);
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    #1;
    `CHK("PA_OE after", 8'hFF, PA_OE);
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK("RDATA", 8'hFF, RDATA);
    wait_cyc(1);
    `CHK("RDATA idle", 8'h00, RDATA);
    // Reset in mid-run clears every register and pin enable.
    @(posedge CLK);
    RESET <= 1'b1;
    {en_a, ext_a, en_b, en_c} <= {8'hFF, 8'h5C, 8'hFF, 8'hFF};
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    `CHK("PA_OE reset", 8'h00, PA_OE);
    `CHK("PA_OUT reset", 8'h00, PA_OUT);
    foreach (rows[i])
    begin
      rd(rows[i].a, d);
      `CHK("reset value", 8'h00, d);
    end
    `CHK("cell A direct", 8'h5C, IMC_BUS_A);
    // Direction of port B stays 0 while its cells take inputs.
    @(posedge CLK);
    ALE <= 1'b1;
    @(posedge CLK);
    ALE <= 1'b0;
    ext_b <= 8'hC3;
    rd(8'h15, d);
    `CHK("cell B read", 8'h3C, d);
    `CHK("cell B bus", 8'h3C, IMC_BUS_B);
    @(posedge CLK);
    IMC_PT <= 6'b010000;
    repeat (2) @(posedge CLK);
    IMC_PT <= '0;
    ext_c <= 8'h11;
    wait_cyc(3);
    `CHK("cell C latch", 8'h05, IMC_BUS_C);
    @(posedge CLK);
    {CFG_OE_PT_B, OE_PT_B, OE_PT_C} <= {8'h0F, 8'h33, 8'hFF};
    {CFG_OE_PT_D, OE_PT_D, en_b, en_c} <= {3'h3, 3'h1, 16'h0000};
    wr(8'h0A, 8'h3C);
    `CHK("PB_OE term", 8'h03, PB_OE);
    `CHK("PD_OE term", 8'h01, PD_OE);
    `CHK("PC_OE no term", 8'h3C, PC_OE);
    @(posedge CLK);
    ADDR_LATCH <= 8'h96;
    en_a <= 8'h00;
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'hF0);
    wr(8'h04, 8'h0A);
    `CHK("address out", 8'h9A, PA_OUT);
    `CHK("address out OE", 8'hFF, PA_OE);
    @(posedge CLK);
    {CFG_LOGIC_OUT_B, MC_OUT_B, CFG_LOGIC_OUT_C} <= {8'hFF, 8'hE7, 8'hFF};
    {MC_OUT_C, MC_OUT_A, CFG_ECS_D} <= {8'h81, 8'h42, 3'h7};
    EXTRA_CHIP_SELECTS <= 3'h5;
    rd(8'h10, d);
    `CHK("cell out read", 8'h42, d);
    `CHK("PB_OUT cell", 8'hE7, PB_OUT);
    `CHK("PC_OUT cell", 8'h81, PC_OUT);
    `CHK("PD_OUT select", 8'h05, PD_OUT);
    wr(8'h0A, 8'h00);
    `CHK("PC_OE cleared", 8'h00, PC_OE);
    wr(8'h18, 8'h80);
    @(posedge CLK);
    PERIPH_WRITE <= 1'b1;
    BUS_DATA <= 8'h5A;
    wait_cyc(2);
    `CHK("periph idle OE", 8'h00, PA_OE);
    @(posedge CLK);
    PERIPH_SELECT_B <= 1'b1 & prog_store;
    wait_cyc(2);
    `CHK("periph OE", 8'hFF, PA_OE);
    `CHK("periph out", 8'h5A, PA_OUT);
    @(posedge CLK);
    PERIPH_WRITE <= 1'b0;
    @(posedge CLK);
    en_a <= 8'hFF;
    ext_a <= 8'h3C;
    wait_cyc(3);
    `CHK("periph in", 8'h3C, PERIPH_DATA);
    // A write while the clock enable is low must leave every flop alone.
    @(posedge CLK);
    CE <= 1'b0;
    wr(8'h0B, 8'h06);
    `CHK("frozen PD_OE", 8'h01, PD_OE);
    @(posedge CLK);
    CE <= 1'b1;
    stop_test();
  end
endmodule
